// >>> hw/rmis_map.svh
// Register map, field positions, reset values and timing counts of the mode sequencer.
// Assumes a 20 MHz system clock and a host that talks to the registers over the SPI configuration port.
//
// Overview of operation
// - Writing one to lock flag clears it.
// - Mode field bits 7:5; 0b010 selects synthesizer.
// - Lock flag sets once synthesizer has locked.
// - Mode value 0b001 selects standby.
// - Mode value zero selects sleep, oscillator, PLL, transmitter, receiver and clock output off.
// - Sync size field 11 selects 32-bit word.
// - Buffered clock output is off in sleep.
// - Sleep refused while any interrupt is active.
// - Sleep keeps registers and SPI port alive.
// - Interrupt wakes device and raises interrupt line.
// - Oscillator active within 5 ms from sleep.
// - PLL locks under 0.5 ms, shown on pin.
// - Entry into sleep completes within 1 ms.
// - Sleep to transmit or receive under 6 ms.
// - FIFO direction bit picks host write or read.
`ifndef RMIS_MAP_SVH
`define RMIS_MAP_SVH

`define RMIS_ADDR_GCON 5'h00
`define RMIS_ADDR_FTPRI 5'h0e
`define RMIS_ADDR_SYNC 5'h12
`define RMIS_ADDR_BUFFERED_CLOCK_OUTPUT 5'h1c
`define RMIS_ADDR_FCRC 5'h1f

`define RMIS_MODE_MSB 7
`define RMIS_MODE_LSB 5
`define RMIS_PLL_FLAG_BIT 1
`define RMIS_PLL_IEN_BIT 0
`define RMIS_SYNC_SZ_MSB 4
`define RMIS_SYNC_SZ_LSB 3
`define RMIS_CLKO_BIT 7
`define RMIS_FDIR_BIT 6

`define RMIS_GCON_RST 8'h20

`define RMIS_CLK_MHZ 20
`define RMIS_XTAL_US 5000
`define RMIS_PLL_US 500
`define RMIS_SLEEP_US 1000
// Longest times round down; the PLL bound is strict, so one cycle less.
`define RMIS_XTAL_CYC (`RMIS_XTAL_US * `RMIS_CLK_MHZ)
`define RMIS_PLL_CYC (`RMIS_PLL_US * `RMIS_CLK_MHZ - 1)
`define RMIS_SLEEP_CYC (`RMIS_SLEEP_US * `RMIS_CLK_MHZ)

`endif

// >>> hw/rmis_pkg.sv
// Types of the mode sequencer.
// Assumes nothing beyond the SystemVerilog type system.
package rmis_pkg;
	typedef enum logic [2:0] {
		MODE_SLEEP = 3'b000,
		MODE_STBY = 3'b001,
		MODE_SYNTH = 3'b010,
		MODE_RX = 3'b011,
		MODE_TX = 3'b100
	} rmis_mode_e;

	typedef enum logic [2:0] {
		ST_SLEEP = 3'b000,
		ST_XTAL = 3'b001,
		ST_STBY = 3'b010,
		ST_SYNTH = 3'b011,
		ST_TX = 3'b100,
		ST_RX = 3'b101,
		ST_PWRDN = 3'b110
	} rmis_state_e;
endpackage

// >>> hw/rmis_mem_if.sv
// Connection between the sequencer and its register storage.
// Assumes both ends run on the same system clock.
interface rmis_mem_if;
	logic we;
	logic [4:0] waddr;
	logic [7:0] wdata;
	logic [4:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> hw/rmis_regmem.sv
// Thirty-two byte configuration storage with a registered read port.
// Assumes one write per cycle from the SPI slave; contents never depend on the operating mode.
module rmis_regmem
	import rmis_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	rmis_mem_if.mem bus
);
	logic [7:0] mem_r [32];
	logic [7:0] mem_nxt [32];
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	// Sleep does not touch this array, so the contents survive it.
	always_comb begin
		mem_nxt = mem_r;
		if (bus.we) begin
			mem_nxt[bus.waddr] = bus.wdata;
		end
		rdata_nxt = mem_r[bus.raddr];
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < 32; i++) begin
				mem_r[i] <= 8'h00;
			end
			rdata_r <= 8'h00;
		end else begin
			mem_r <= mem_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign bus.rdata = rdata_r;
endmodule

// >>> hw/rmis_seq.sv
// Operating-mode sequencer with its SPI configuration port.
// Assumes SPI mode 0 frames of 16 bits under an active-low chip select, far slower than the system clock,
// and interrupt sources from the packet engine on the same clock.
`include "rmis_map.svh"
module rmis_seq
	import rmis_pkg::*;
#(
	parameter int XTAL_CYC = `RMIS_XTAL_CYC,
	parameter int PLL_CYC = `RMIS_PLL_CYC,
	parameter int SLEEP_CYC = `RMIS_SLEEP_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic config_chip_select_b_i,
	input wire logic spi_sck_i,
	input wire logic spi_sdi_i,
	input wire logic radio_event_interrupt_line_zero_i,
	input wire logic radio_event_interrupt_line_one_i,
	output logic spi_sdo_o,
	output logic spi_sdo_oe_o,
	output logic interrupt_line_zero_o,
	output logic interrupt_line_one_o,
	output logic pll_locked_pin_o,
	output logic buffered_clock_output_o,
	output logic osc_enable_o,
	output logic pll_enable_o,
	output logic tx_enable_o,
	output logic rx_enable_o,
	output logic fifo_host_write_en_o,
	output logic fifo_host_read_en_o,
	output logic [5:0] sync_word_len_o,
	output logic [2:0] mode_state_o
);
	localparam logic [16:0] XTAL_N = 17'(XTAL_CYC - 1);
	localparam logic [16:0] PLL_N = 17'(PLL_CYC - 1);
	localparam logic [16:0] SLEEP_N = 17'(SLEEP_CYC - 1);

	function automatic logic synth_family(input rmis_state_e st);
		return st == ST_SYNTH || st == ST_TX || st == ST_RX;
	endfunction

	rmis_mem_if mem_bus ();
	rmis_regmem u_mem (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus(mem_bus));

	// Pin synchronisers: stage 0 feeds only stage 1; only the serial clock has a stage 2, kept for edge detection.
	logic [2:0] sck_r, sck_nxt;
	logic [1:0] cs_r, cs_nxt, sdi_r, sdi_nxt;
	always_comb begin
		sck_nxt = {sck_r[1:0], spi_sck_i};
		cs_nxt = {cs_r[0], config_chip_select_b_i};
		sdi_nxt = {sdi_r[0], spi_sdi_i};
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			sck_r <= 3'h0;
			cs_r <= 2'h3;
			sdi_r <= 2'h0;
		end else begin
			sck_r <= sck_nxt;
			cs_r <= cs_nxt;
			sdi_r <= sdi_nxt;
		end
	end
	logic sck_rise, sck_fall, cs_act;
	assign sck_rise = sck_r[1] & ~sck_r[2];
	assign sck_fall = ~sck_r[1] & sck_r[2];
	assign cs_act = ~cs_r[1];

	// SPI slave: command byte {start, read, addr[4:0], stop}, then one data byte.
	logic [4:0] bit_cnt_r, bit_cnt_nxt, addr_r, addr_nxt;
	logic [7:0] in_sh_r, in_sh_nxt, out_sh_r, out_sh_nxt, rd_merged, wdata;
	logic cmd_rd_r, cmd_rd_nxt, sdo_oe_r, sdo_oe_nxt, wr_en;
	logic [7:0] gcon_r, gcon_nxt;
	logic pll_flag_r, pll_flag_nxt, pll_ien_r, pll_ien_nxt, clko_en_r, clko_en_nxt, fdir_r, fdir_nxt;
	logic [1:0] sync_sz_r, sync_sz_nxt;

	assign wdata = {in_sh_r[6:0], sdi_r[1]};
	assign wr_en = cs_act & sck_rise & (bit_cnt_r == 5'h0f) & ~cmd_rd_r;

	always_comb begin
		rd_merged = mem_bus.rdata;
		if (addr_r == `RMIS_ADDR_GCON) begin
			rd_merged = gcon_r;
		end else if (addr_r == `RMIS_ADDR_FTPRI) begin
			rd_merged[`RMIS_PLL_FLAG_BIT] = pll_flag_r;
		end
	end

	// The port runs in every state, sleep included.
	always_comb begin
		bit_cnt_nxt = bit_cnt_r;
		addr_nxt = addr_r;
		in_sh_nxt = in_sh_r;
		out_sh_nxt = out_sh_r;
		cmd_rd_nxt = cmd_rd_r;
		sdo_oe_nxt = sdo_oe_r;
		if (!cs_act) begin
			bit_cnt_nxt = 5'h00;
			sdo_oe_nxt = 1'b0;
		end else begin
			if (sck_rise) begin
				in_sh_nxt = wdata;
				bit_cnt_nxt = (bit_cnt_r == 5'h0f) ? 5'h00 : bit_cnt_r + 5'h01;
				if (bit_cnt_r == 5'h07) begin
					cmd_rd_nxt = in_sh_r[5];
					addr_nxt = in_sh_r[4:0];
				end
			end
			if (sck_fall) begin
				sdo_oe_nxt = cmd_rd_r & (bit_cnt_r >= 5'h08);
				out_sh_nxt = (bit_cnt_r == 5'h08) ? rd_merged : {out_sh_r[6:0], 1'b0};
			end
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			bit_cnt_r <= 5'h00;
			addr_r <= 5'h00;
			in_sh_r <= 8'h00;
			out_sh_r <= 8'h00;
			cmd_rd_r <= 1'b0;
			sdo_oe_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			addr_r <= addr_nxt;
			in_sh_r <= in_sh_nxt;
			out_sh_r <= out_sh_nxt;
			cmd_rd_r <= cmd_rd_nxt;
			sdo_oe_r <= sdo_oe_nxt;
		end
	end
	assign mem_bus.we = wr_en;
	assign mem_bus.waddr = addr_r;
	assign mem_bus.wdata = wdata;
	assign mem_bus.raddr = addr_r;

	// Control fields that steer the sequencer.
	rmis_state_e state_r, state_nxt;
	logic locked_r, locked_nxt, lock_evt;
	assign lock_evt = locked_nxt & ~locked_r;
	always_comb begin
		gcon_nxt = gcon_r;
		pll_ien_nxt = pll_ien_r;
		sync_sz_nxt = sync_sz_r;
		clko_en_nxt = clko_en_r;
		fdir_nxt = fdir_r;
		pll_flag_nxt = pll_flag_r;
		if (wr_en) begin
			unique case (addr_r)
				`RMIS_ADDR_GCON: gcon_nxt = wdata;
				`RMIS_ADDR_FTPRI: begin
					pll_ien_nxt = wdata[`RMIS_PLL_IEN_BIT];
					if (wdata[`RMIS_PLL_FLAG_BIT]) begin
						pll_flag_nxt = 1'b0;
					end
				end
				`RMIS_ADDR_SYNC: sync_sz_nxt = wdata[`RMIS_SYNC_SZ_MSB:`RMIS_SYNC_SZ_LSB];
				`RMIS_ADDR_BUFFERED_CLOCK_OUTPUT: clko_en_nxt = wdata[`RMIS_CLKO_BIT];
				`RMIS_ADDR_FCRC: fdir_nxt = wdata[`RMIS_FDIR_BIT];
				default: ;
			endcase
		end
		// A lock in the same cycle as the clear wins; loss of lock never clears the flag.
		if (lock_evt) begin
			pll_flag_nxt = 1'b1;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			gcon_r <= `RMIS_GCON_RST;
			pll_ien_r <= 1'b0;
			sync_sz_r <= 2'h0;
			clko_en_r <= 1'b0;
			fdir_r <= 1'b0;
			pll_flag_r <= 1'b0;
		end else begin
			gcon_r <= gcon_nxt;
			pll_ien_r <= pll_ien_nxt;
			sync_sz_r <= sync_sz_nxt;
			clko_en_r <= clko_en_nxt;
			fdir_r <= fdir_nxt;
			pll_flag_r <= pll_flag_nxt;
		end
	end

	// Mode sequencer.
	rmis_mode_e cmd;
	logic [16:0] cnt_r, cnt_nxt;
	logic interrupt_line_zero_r, interrupt_line_zero_nxt, interrupt_line_one_r, interrupt_line_one_nxt, irq_any, go_sleep;
	logic clk_out_r, clk_out_nxt, osc_r, osc_nxt, pll_en_r, pll_en_nxt, tx_r, tx_nxt, rx_r, rx_nxt;
	logic fwr_r, fwr_nxt, frd_r, frd_nxt, lock_pin_r;
	logic [5:0] sync_len_r, sync_len_nxt;
	assign cmd = rmis_mode_e'(gcon_r[`RMIS_MODE_MSB:`RMIS_MODE_LSB]);
	assign irq_any = interrupt_line_zero_r | interrupt_line_one_r;
	assign go_sleep = (cmd == MODE_SLEEP) & ~irq_any;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_SLEEP: if (cmd != MODE_SLEEP || irq_any) state_nxt = ST_XTAL;
			ST_XTAL: if (cnt_r == XTAL_N) state_nxt = ST_STBY;
			// A sleep request refused for an active interrupt waits in standby, not in the synthesizer.
			ST_STBY: begin
				if (go_sleep) state_nxt = ST_PWRDN;
				else if (cmd != MODE_STBY && cmd != MODE_SLEEP) state_nxt = ST_SYNTH;
			end
			ST_SYNTH, ST_TX, ST_RX: begin
				if (go_sleep) state_nxt = ST_PWRDN;
				else if (cmd == MODE_STBY || cmd == MODE_SLEEP) state_nxt = ST_STBY;
				else if (cmd == MODE_SYNTH) state_nxt = ST_SYNTH;
				else if (locked_r) state_nxt = (cmd == MODE_TX) ? ST_TX : ST_RX;
			end
			ST_PWRDN: begin
				if (!go_sleep) state_nxt = ST_STBY;
				else if (cnt_r == SLEEP_N) state_nxt = ST_SLEEP;
			end
			default: state_nxt = ST_STBY;
		endcase
		// Timers restart on every state change.
		cnt_nxt = (state_nxt != state_r) ? 17'h00000 : cnt_r + {16'h0000, cnt_r != 17'h1ffff};
		locked_nxt = synth_family(state_nxt) & (locked_r | (state_r == ST_SYNTH && cnt_r == PLL_N));
		interrupt_line_zero_nxt = radio_event_interrupt_line_zero_i;
		interrupt_line_one_nxt = radio_event_interrupt_line_one_i | (pll_flag_r & pll_ien_r);
		osc_nxt = state_nxt != ST_SLEEP;
		pll_en_nxt = synth_family(state_nxt);
		tx_nxt = state_nxt == ST_TX;
		rx_nxt = state_nxt == ST_RX;
		clk_out_nxt = (state_nxt != ST_SLEEP && clko_en_r) ? ~clk_out_r : 1'b0;
		fwr_nxt = (state_nxt == ST_STBY) & ~fdir_r;
		frd_nxt = (state_nxt == ST_STBY) & fdir_r;
		sync_len_nxt = {sync_sz_r + 2'h1 == 2'h0, sync_sz_r + 2'h1, 3'h0};
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			state_r <= ST_STBY;
			cnt_r <= 17'h00000;
			locked_r <= 1'b0;
			lock_pin_r <= 1'b0;
			interrupt_line_zero_r <= 1'b0;
			interrupt_line_one_r <= 1'b0;
			osc_r <= 1'b1;
			pll_en_r <= 1'b0;
			tx_r <= 1'b0;
			rx_r <= 1'b0;
			clk_out_r <= 1'b0;
			fwr_r <= 1'b0;
			frd_r <= 1'b0;
			sync_len_r <= 6'h08;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			locked_r <= locked_nxt;
			lock_pin_r <= locked_nxt;
			interrupt_line_zero_r <= interrupt_line_zero_nxt;
			interrupt_line_one_r <= interrupt_line_one_nxt;
			osc_r <= osc_nxt;
			pll_en_r <= pll_en_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			clk_out_r <= clk_out_nxt;
			fwr_r <= fwr_nxt;
			frd_r <= frd_nxt;
			sync_len_r <= sync_len_nxt;
		end
	end

	assign spi_sdo_o = out_sh_r[7];
	assign spi_sdo_oe_o = sdo_oe_r;
	assign interrupt_line_zero_o = interrupt_line_zero_r;
	assign interrupt_line_one_o = interrupt_line_one_r;
	assign pll_locked_pin_o = lock_pin_r;
	assign buffered_clock_output_o = clk_out_r;
	assign osc_enable_o = osc_r;
	assign pll_enable_o = pll_en_r;
	assign tx_enable_o = tx_r;
	assign rx_enable_o = rx_r;
	assign fifo_host_write_en_o = fwr_r;
	assign fifo_host_read_en_o = frd_r;
	assign sync_word_len_o = sync_len_r;
	assign mode_state_o = state_r;

	flag_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		wr_en && addr_r == `RMIS_ADDR_FTPRI && wdata[1] && !lock_evt |=> !pll_flag_r)
		else $error("lock flag not cleared by write of one");
	synth_entry_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		state_r == ST_STBY && cmd == MODE_SYNTH |=> state_r == ST_SYNTH && pll_enable_o)
		else $error("synthesizer code did not start the synthesizer");
	flag_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		pll_flag_r && !(wr_en && addr_r == `RMIS_ADDR_FTPRI) |=> pll_flag_r)
		else $error("lock flag dropped without a host clear");
	stby_return_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		synth_family(state_r) && cmd == MODE_STBY |=> state_r == ST_STBY && !pll_enable_o)
		else $error("standby code did not return to standby");
	sleep_buffered_clock_output_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		state_r == ST_SLEEP |-> !buffered_clock_output_o && !osc_enable_o)
		else $error("clock output running in sleep");
	sleep_refuse_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		irq_any |=> state_r != ST_SLEEP)
		else $error("sleep entered with an interrupt active");
	irq_wake_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		state_r == ST_SLEEP && irq_any |=> state_r == ST_XTAL && osc_enable_o)
		else $error("interrupt did not wake the device");
	xtal_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		state_r == ST_XTAL |-> cnt_r <= XTAL_N)
		else $error("oscillator start exceeded its bound");
	lock_pin_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		$rose(pll_locked_pin_o) |-> $past(state_r) == ST_SYNTH && pll_flag_r)
		else $error("lock pin rose outside synthesizer lock");
	sync_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		sync_sz_r == 2'h3 |=> sync_word_len_o == 6'd32)
		else $error("sync size 11 did not give a 32-bit word");
	fifo_dir_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		fifo_host_read_en_o |-> !fifo_host_write_en_o && $past(fdir_r))
		else $error("FIFO direction not honoured");
endmodule

// >>> verif/rmis_host_model.sv
// Behavioural host that reaches the sequencer registers through 16-bit SPI mode 0 frames.
// Assumes a 400 ns serial clock that stands low outside frames and a caller that starts just after a system edge.
module rmis_host_model (
	output logic cs_b_o,
	output logic sck_o,
	output logic sdi_o,
	input wire logic sdo_i,
	input wire logic sdo_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// Between frames the lines are parked for the lowest sleep current.
	initial begin
		cs_b_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end

	task automatic xfer(input logic rd, input logic [4:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
		logic [15:0] fr;
		fr = {1'b0, rd, addr, 1'b0, wd};
		rdat = 8'h00;
		cs_b_o = 1'b0;
		#200;
		for (int i = 15; i >= 0; i--) begin
			sdi_o = fr[i];
			#200;
			sck_o = 1'b1;
			// An undriven data line reads as the inverse, so a missing output enable spoils the byte.
			if (i < 8)
				rdat[i] = sdo_oe_i ? sdo_i : ~sdo_i;
			#200;
			sck_o = 1'b0;
		end
		#200;
		cs_b_o = 1'b1;
		sdi_o = 1'b0;
		#400;
	endtask
endmodule

// >>> verif/radio_mode_init_sequencer_tb_top.sv
// Self-checking bench of the mode sequencer, driven by the behavioural SPI host.
// Assumes the sequencer is built with shortened oscillator, lock and sleep-entry counts.
module radio_mode_init_sequencer_tb_top import rmis_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	localparam int XC = 20;
	localparam int PC = 10;
	localparam int SC = 8;
	logic clk, rst_b, interrupt_line_zero, interrupt_line_one, cs_b, sck, sdi, sdo, sdo_oe;
	logic il0, il1, pll_pin, bco, osc_en, pll_en, tx_en, rx_en, fw, fr;
	logic [5:0] swl;
	logic [2:0] ms;
	logic [7:0] obs_q[$];
	logic [7:0] exp_q[$];
	event res_ev;
	int n_fail = 0;
	int comparisons = 0;
	int seed = 43;

	rmis_seq #(.XTAL_CYC(XC), .PLL_CYC(PC), .SLEEP_CYC(SC)) i_dut (
		.clk_sys_i(clk), .rst_b_i(rst_b), .config_chip_select_b_i(cs_b), .spi_sck_i(sck), .spi_sdi_i(sdi),
		.radio_event_interrupt_line_zero_i(interrupt_line_zero), .radio_event_interrupt_line_one_i(interrupt_line_one), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
		.interrupt_line_zero_o(il0), .interrupt_line_one_o(il1), .pll_locked_pin_o(pll_pin),
		.buffered_clock_output_o(bco), .osc_enable_o(osc_en), .pll_enable_o(pll_en), .tx_enable_o(tx_en),
		.rx_enable_o(rx_en), .fifo_host_write_en_o(fw), .fifo_host_read_en_o(fr), .sync_word_len_o(swl),
		.mode_state_o(ms)
	);

	rmis_host_model i_host (.cs_b_o(cs_b), .sck_o(sck), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic give_verdict();
		// The watcher drains the last notes before the counts are printed.
		#1;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [7:0] obs, input logic [7:0] exp);
		exp_q.push_back(exp);
		obs_q.push_back(obs);
		-> res_ev;
	endtask

	// The watcher owns the comparison so every noted result is judged in order, without shifting the stimulus phase.
	initial begin
		logic [7:0] e, o;
		forever begin
			@(res_ev);
			while (exp_q.size() > 0) begin
				e = exp_q.pop_front();
				o = obs_q.pop_front();
				comparisons++;
				if (o !== e) begin
					n_fail++;
					$display("unexpected at %0t: got %h expected %h", $time, o, e);
				end
			end
		end
	end

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] x;
		i_host.xfer(1'b0, a, d, x);
	endtask

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		i_host.xfer(1'b1, a, 8'h00, d);
	endtask

	task automatic wait_state(input rmis_state_e st, input int bound);
		int n;
		n = 0;
		while (ms !== st && n < bound) begin
			@(posedge clk);
			#2;
			n++;
		end
		check({5'h00, ms}, {5'h00, st});
		if (ms !== st)
			give_verdict();
	endtask

	initial begin
		#1000000;
		n_fail++;
		give_verdict();
	end

	initial begin
		logic [7:0] d, v, sv;
		logic b;
		rst_b = 1'b0;
		interrupt_line_zero = 1'b0;
		interrupt_line_one = 1'b0;
		repeat (4) @(posedge clk);
		#2 rst_b = 1'b1;
		repeat (4) @(posedge clk);
		#2;
		check({5'h00, ms}, {5'h00, ST_STBY});
		// Full initialisation pass: mode register first, then every location in ascending order.
		for (int a = 0; a < 32; a++) begin
			v = 8'($random(seed));
			if (a == 0)
				v = 8'h20;
			if (a == 14)
				v[1:0] = 2'b10;
			wr(5'(a), v);
		end
		rd(5'h1f, d);
		check(d, v);
		rd(5'h00, d);
		check(d, 8'h20);
		wr(5'h0e, 8'h03);
		rd(5'h0e, d);
		check(d & 8'h02, 8'h00);
		wr(5'h00, 8'h40);
		wait_state(ST_SYNTH, 5);
		repeat (PC + 3) @(posedge clk);
		#2;
		check({6'h00, pll_pin, il1}, 8'h03);
		rd(5'h0e, d);
		check(d & 8'h02, 8'h02);
		wr(5'h00, 8'h20);
		wait_state(ST_STBY, 5);
		rd(5'h0e, d);
		check({d[1], pll_pin}, 2'b10);
		wr(5'h0e, 8'h02);
		rd(5'h0e, d);
		check({d[1], il1}, 2'b00);
		for (int k = 0; k < 2; k++) begin
			wr(5'h00, k ? 8'h60 : 8'h80);
			wait_state(k ? ST_RX : ST_TX, 2 * PC);
			check({6'h00, tx_en, rx_en}, k ? 8'h01 : 8'h02);
			wr(5'h00, 8'h20);
			wait_state(ST_STBY, 5);
		end
		for (int s = 0; s < 4; s++) begin
			v = 8'($random(seed));
			v[4:3] = s[1:0];
			wr(5'h12, v);
			check({2'b00, swl}, 8'(8 * (s + 1)));
			rd(5'h12, d);
			check(d, v);
			sv = v;
		end
		wr(5'h1f, 8'h40);
		check({6'h00, fw, fr}, 8'h01);
		wr(5'h1f, 8'h00);
		check({6'h00, fw, fr}, 8'h02);
		wr(5'h1c, 8'h80);
		b = bco;
		@(posedge clk);
		#2;
		check({7'h00, bco}, {7'h00, ~b});
		interrupt_line_zero = 1'b1;
		wr(5'h00, 8'h00);
		repeat (3 * SC) @(posedge clk);
		#2;
		check({4'h0, ms, il0}, {4'h0, ST_STBY, 1'h1});
		wr(5'h00, 8'h20);
		wait_state(ST_STBY, 5);
		interrupt_line_zero = 1'b0;
		repeat (3) @(posedge clk);
		#2;
		wr(5'h00, 8'h00);
		wait_state(ST_SLEEP, SC + 5);
		b = bco;
		@(posedge clk);
		#2;
		check({5'h00, b, bco, osc_en | pll_en}, 8'h00);
		rd(5'h12, d);
		check(d, sv);
		check({5'h00, ms}, {5'h00, ST_SLEEP});
		interrupt_line_one = 1'b1;
		@(posedge clk);
		#2;
		wait_state(ST_STBY, XC + 10);
		check({7'h00, il1}, 8'h01);
		interrupt_line_one = 1'b0;
		repeat (3) @(posedge clk);
		give_verdict();
	end
endmodule
